// [common/tw_pkg.sv]
// Shared constants, carriers and states of the two-wire bus master
package tw_pkg;
    // System clock period and quarter of a 400 kHz bit period
    localparam int CLK_PERIOD_NS = 5;
    localparam int QUARTER_NS = 625;
    // Least time rounds up to whole cycles
    localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RSP_DEPTH = 2;
    // Bit index of the acknowledge slot in a nine-bit packet
    localparam logic [3:0] ACK_IDX = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    // General call address with the read bit set
    localparam logic [7:0] GC_READ = 8'h01;
    // Upper nibble of the reserved address group
    localparam logic [3:0] RESV_HI = 4'hF;
    // Sub-steps inside a phase
    localparam logic [1:0] SEQ_A = 2'h0;
    localparam logic [1:0] SEQ_B = 2'h1;
    localparam logic [1:0] SEQ_C = 2'h2;

    // One byte job: optional START before, optional STOP after
    typedef struct packed {
        logic start;
        logic stop;
        logic rx;
        logic nack;
        logic [7:0] data;
    } tw_cmd_t;

    // Result of one job
    typedef struct packed {
        logic [7:0] data;
        logic nack;
        logic err;
        logic resv;
    } tw_rsp_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_LOW = 6'h04,
        ST_HIGH = 6'h08,
        ST_PUSH = 6'h10,
        ST_STOP = 6'h20
    } tw_state_t;
endpackage

// [design/tw_buf.sv]
// Small valid/ready buffer for the response path
module tw_buf #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW:0] ONE = (AW + 1)'(1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] STEP = AW'(1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("tw_buf needs at least two entries");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;

    // Honest flags from the occupancy count
    assign in_ready = count != FULL;
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    // Storage written only on an accepted word
    always_ff @(posedge clk_sys)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + STEP;
            end
            if (do_rd)
            begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + STEP;
            end
            if (do_wr && !do_rd)
            begin
                count <= count + ONE;
            end
            else if (do_rd && !do_wr)
            begin
                count <= count - ONE;
            end
        end
    end
endmodule

// [design/tw_master.sv]
// Host-side master engine for the shared two-wire bus
//
// Behaviour
// R01 - Hold SDA steady while SCL is high
// R02 - START/STOP are SDA edges during SCL high
// R03 - Bus busy from START until STOP
// R04 - Repeated START keeps bus owned until STOP
// R05 - Address packet: seven bits, direction, acknowledge
// R06 - Direction bit one means read
// R07 - Addressed slave acks by pulling SDA low
// R08 - Nack on address; master then STOP/restart
// R09 - Address byte goes out MSB first
// R10 - All-zero address is general call write
// R11 - Never send general call with read
// R12 - Upper nibble all ones is reserved
// R13 - Data packet: byte MSB first plus acknowledge
// R14 - Master alone clocks; receiver gives acknowledge
// R15 - Receiver nacks after its last byte
// R16 - No START directly followed by STOP
// R17 - Wait while a slave holds SCL low
// R18 - Master alone sets the SCL high time
// R19 - Lines only pulled low or released
// R20 - Device serves every role up to 400k; this engine is master transmitter and receiver only
// R21 - Transmitter releases SDA in acknowledge slot
module tw_master #(
    parameter int Q_CYC = tw_pkg::QUARTER_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire tw_pkg::tw_cmd_t cmd,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output tw_pkg::tw_rsp_t rsp,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic bus_busy,
    output logic bus_owned
);
    localparam int CW = $clog2(2 * Q_CYC);
    localparam logic [CW-1:0] Q_LD = CW'(Q_CYC - 1);
    localparam logic [CW-1:0] H_LD = CW'(2 * Q_CYC - 1);
    localparam logic [CW-1:0] CNT_STEP = CW'(1);

    if (Q_CYC < 2 || Q_CYC > 1000) begin : g_chk
        $error("tw_master quarter period out of range");
    end

    tw_pkg::tw_state_t st;
    tw_pkg::tw_state_t next_st;
    tw_pkg::tw_cmd_t cur;
    tw_pkg::tw_cmd_t next_cur;
    logic [1:0] seq;
    logic [1:0] next_seq;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic nack_seen;
    logic next_nack_seen;
    logic rsp_err;
    logic next_rsp_err;
    logic next_scl_oe;
    logic next_sda_oe;
    logic next_owned;
    logic scl_s1;
    logic scl_h;
    logic sda_s1;
    logic sda_h;
    logic sda_d;
    logic buf_ready;

    // R19 only low or released
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Pin sampling: first stage feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            scl_s1 <= 1'b1;
            scl_h <= 1'b1;
            sda_s1 <= 1'b1;
            sda_h <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_s1 <= scl_i;
            scl_h <= scl_s1;
            sda_s1 <= sda_i;
            sda_h <= sda_s1;
            sda_d <= sda_h;
        end
    end

    // R02 conditions seen as SDA edges with SCL high
    wire start_seen = scl_h && sda_d && !sda_h;
    wire stop_seen = scl_h && !sda_d && sda_h;

    // R03 busy tracker, also watches other masters
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            bus_busy <= 1'b0;
        end
        else if (start_seen)
        begin
            bus_busy <= 1'b1;
        end
        else if (stop_seen)
        begin
            bus_busy <= 1'b0;
        end
    end

    // Phase timer pauses while a slave stretches the clock
    wire wait_high = (st == tw_pkg::ST_HIGH)
        || ((st == tw_pkg::ST_START || st == tw_pkg::ST_STOP) && seq == tw_pkg::SEQ_B);
    // R17 timer held until SCL really high
    wire run = !wait_high || scl_h;
    wire done = (cnt == '0) && run;

    // R10 general call write goes out like any address
    // R11 general call read is refused
    // R06 direction bit one is read
    wire gc_read_bad = cmd.start && (cmd.data == tw_pkg::GC_READ);
    // R16 a byte job without START needs an owned bus
    wire orphan = !cmd.start && !bus_owned;
    wire take_err = gc_read_bad || orphan;
    // R03 start only on a free or owned bus
    wire take_start = cmd.start && (bus_owned || !bus_busy);
    wire take_byte = !cmd.start && bus_owned;
    assign cmd_ready = (st == tw_pkg::ST_IDLE) && (take_err || take_start || take_byte);
    wire accept = cmd_valid && cmd_ready;

    // R20 transmit or receive chosen per job
    // R09 MSB first from the top of the shifter
    // R15 receiver acks unless told last byte
    // R21 transmitter releases in acknowledge slot
    wire bit_drive = (bit_idx == tw_pkg::ACK_IDX) ? (cur.rx && !cur.nack) : (!cur.rx && !sh[7]);
    // R12 reserved address flagged back to the user
    wire resv_addr = cur.start && (cur.data[7:4] == tw_pkg::RESV_HI);
    wire push_go = (st == tw_pkg::ST_PUSH) && done && buf_ready;
    wire stop_after = cur.stop && !rsp_err;

    tw_pkg::tw_rsp_t rsp_in;
    assign rsp_in = '{data: sh, nack: nack_seen, err: rsp_err, resv: resv_addr};

    // Sequencer next-state decode
    always_comb
    begin
        next_st = st;
        next_cur = cur;
        next_seq = seq;
        next_cnt = (cnt != '0 && run) ? cnt - CNT_STEP : cnt;
        next_bit_idx = bit_idx;
        next_sh = sh;
        next_nack_seen = nack_seen;
        next_rsp_err = rsp_err;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_owned = bus_owned;
        unique case (st)
            tw_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    next_cur = cmd;
                    next_rsp_err = take_err;
                    next_sh = cmd.data;
                    next_nack_seen = 1'b0;
                    next_seq = tw_pkg::SEQ_A;
                    next_cnt = Q_LD;
                    next_bit_idx = tw_pkg::BIT_FIRST;
                    if (take_err)
                    begin
                        next_st = tw_pkg::ST_PUSH;
                    end
                    else if (take_start)
                    begin
                        // R04 restart from an owned bus
                        next_st = tw_pkg::ST_START;
                        next_sda_oe = 1'b0;
                    end
                    else
                    begin
                        next_st = tw_pkg::ST_LOW;
                    end
                end
            end
            tw_pkg::ST_START:
            begin
                if (done && seq == tw_pkg::SEQ_A)
                begin
                    next_scl_oe = 1'b0;
                    next_seq = tw_pkg::SEQ_B;
                    next_cnt = Q_LD;
                end
                else if (done && seq == tw_pkg::SEQ_B)
                begin
                    // R02 SDA falls while SCL high
                    next_sda_oe = 1'b1;
                    next_owned = 1'b1;
                    next_seq = tw_pkg::SEQ_C;
                    next_cnt = H_LD;
                end
                else if (done)
                begin
                    // R14 master pulls the clock low
                    next_scl_oe = 1'b1;
                    next_st = tw_pkg::ST_LOW;
                    next_seq = tw_pkg::SEQ_A;
                    next_cnt = Q_LD;
                end
            end
            tw_pkg::ST_LOW:
            begin
                if (done && seq == tw_pkg::SEQ_A)
                begin
                    // R01 data changes only mid low phase
                    next_sda_oe = bit_drive;
                    next_seq = tw_pkg::SEQ_B;
                    next_cnt = Q_LD;
                end
                else if (done)
                begin
                    next_scl_oe = 1'b0;
                    next_st = tw_pkg::ST_HIGH;
                    next_cnt = H_LD;
                end
            end
            tw_pkg::ST_HIGH:
            begin
                // R18 high time counted from seen high
                if (done)
                begin
                    next_scl_oe = 1'b1;
                    next_cnt = Q_LD;
                    next_seq = tw_pkg::SEQ_A;
                    // R05 R13 nine clocked bits per packet
                    if (bit_idx == tw_pkg::ACK_IDX)
                    begin
                        // R07 R08 slave acknowledge captured
                        next_nack_seen = sda_h;
                        next_st = tw_pkg::ST_PUSH;
                    end
                    else
                    begin
                        next_sh = {sh[6:0], sda_h};
                        next_bit_idx = bit_idx + tw_pkg::BIT_STEP;
                        next_st = tw_pkg::ST_LOW;
                    end
                end
            end
            tw_pkg::ST_PUSH:
            begin
                // Full buffer stalls here, with SCL held low unless the job was refused on a bus not owned
                if (push_go)
                begin
                    next_seq = tw_pkg::SEQ_A;
                    next_cnt = Q_LD;
                    next_sda_oe = stop_after;
                    next_st = stop_after ? tw_pkg::ST_STOP : tw_pkg::ST_IDLE;
                end
            end
            tw_pkg::ST_STOP:
            begin
                if (done && seq == tw_pkg::SEQ_A)
                begin
                    next_scl_oe = 1'b0;
                    next_seq = tw_pkg::SEQ_B;
                    next_cnt = Q_LD;
                end
                else if (done && seq == tw_pkg::SEQ_B)
                begin
                    // R02 SDA rises while SCL high
                    next_sda_oe = 1'b0;
                    next_seq = tw_pkg::SEQ_C;
                    next_cnt = H_LD;
                end
                else if (done)
                begin
                    next_owned = 1'b0;
                    next_st = tw_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Control state registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st <= tw_pkg::ST_IDLE;
            seq <= tw_pkg::SEQ_A;
            cnt <= '0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            bus_owned <= 1'b0;
        end
        else
        begin
            st <= next_st;
            seq <= next_seq;
            cnt <= next_cnt;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            bus_owned <= next_owned;
        end
    end

    // Job data registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cur <= '0;
            bit_idx <= tw_pkg::BIT_FIRST;
            sh <= '0;
            nack_seen <= 1'b0;
            rsp_err <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
            bit_idx <= next_bit_idx;
            sh <= next_sh;
            nack_seen <= next_nack_seen;
            rsp_err <= next_rsp_err;
        end
    end

    // Response buffer so a slow reader loses no result
    tw_buf #(
        .WIDTH($bits(tw_pkg::tw_rsp_t)),
        .DEPTH(tw_pkg::RSP_DEPTH)
    ) u_rsp_buf (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(push_go),
        .in_ready(buf_ready),
        .in_data(rsp_in),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data(rsp)
    );

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sda_stable_a: assert property (st == tw_pkg::ST_HIGH && $past(st == tw_pkg::ST_HIGH) |-> $stable(sda_oe)) // R01
        else $error("sda moved during clock high");
    start_edge_a: assert property ($rose(sda_oe) && !scl_oe |-> $past(st == tw_pkg::ST_START)) // R02
        else $error("sda pulled low with clock high outside start");
    busy_gate_a: assert property (st == tw_pkg::ST_IDLE && next_st == tw_pkg::ST_START |-> bus_owned || !bus_busy) // R03
        else $error("start attempted on busy bus");
    own_keep_a: assert property (st == tw_pkg::ST_START && seq == tw_pkg::SEQ_B && done |=> bus_owned [*2]) // R04
        else $error("bus not owned after start");
    nine_bits_a: assert property (st == tw_pkg::ST_HIGH && next_st == tw_pkg::ST_PUSH |-> bit_idx == tw_pkg::ACK_IDX) // R05
        else $error("packet not nine bits");
    msb_first_a: assert property (st == tw_pkg::ST_HIGH && !cur.rx && bit_idx != tw_pkg::ACK_IDX |-> sda_oe == !sh[7]) // R09
        else $error("transmit bit not msb of shifter");
    gc_read_a: assert property (accept && gc_read_bad |=> st == tw_pkg::ST_PUSH ##1 st != tw_pkg::ST_START) // R11
        else $error("general call read went out");
    ack_release_a: assert property (st == tw_pkg::ST_HIGH && bit_idx == tw_pkg::ACK_IDX && !cur.rx |-> !sda_oe) // R21
        else $error("transmitter drove acknowledge slot");
    rx_ack_a: assert property (st == tw_pkg::ST_HIGH && bit_idx == tw_pkg::ACK_IDX && cur.rx |-> sda_oe == !cur.nack) // R15
        else $error("receiver acknowledge level wrong");
    stretch_wait_a: assert property (st == tw_pkg::ST_HIGH && !scl_h |=> st == tw_pkg::ST_HIGH && $stable(cnt)) // R17
        else $error("timer ran while clock stretched");

    read_byte_c: cover property (push_go && cur.rx);
    restart_c: cover property (st == tw_pkg::ST_START && seq == tw_pkg::SEQ_B && bus_owned);
    stretch_c: cover property ((st == tw_pkg::ST_HIGH && !scl_h && !scl_oe) [*4]);
    stop_done_c: cover property (st == tw_pkg::ST_STOP && next_st == tw_pkg::ST_IDLE);
endmodule

// [dv/tw_slave_model.sv]
// Behavioural slave on the shared two-wire bus, pulls lines low only
module tw_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A,
    parameter logic [7:0] TX_BYTE = 8'hC3
) (
    input wire logic clk_sys,
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] stretch,
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count,
    output logic got_nack
);
    timeunit 1ns;
    timeprecision 100ps;
    int bitn = 0;
    logic [7:0] sh = 8'h00;
    logic addr_ph = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    initial
    begin
        {scl_pull, sda_pull, got_nack} = 3'h0;
        {rx_byte, rx_count} = 16'h0000;
    end
    // an SDA fall with SCL high opens a packet
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            bitn = 0;
            addr_ph = 1'b1;
            sel = 1'b0;
            sda_pull = 1'b0;
        end
    // nine clocked bits, first eight shift MSB first
    always @(posedge scl)
    begin
        if (bitn < 8)
            sh = {sh[6:0], sda};
        else if (sel && rd)
            got_nack = sda;
        bitn = bitn + 1;
    end
    // Changes land well after SCL falls, never while it is high
    always @(negedge scl)
    begin
        #12;
        if (bitn == 8 && addr_ph)
        begin
            // pull low only for own or general call write
            rd = sh[0];
            sel = sh[7:1] == ADDR || sh == 8'h00;
            sda_pull = sel;
        end
        else if (bitn == 8 && sel && !rd)
        begin
            rx_byte = sh;
            rx_count = rx_count + 8'h01;
            sda_pull = 1'b1;
        end
        else if (bitn == 8)
            sda_pull = 1'b0;
        else if (bitn == 9)
        begin
            bitn = 0;
            addr_ph = 1'b0;
            // release after the slot; a NACK from the master ends the read
            sda_pull = 1'b0;
            sel = sel && !(rd && got_nack);
        end
        // read bits go out MSB first while SCL is low
        if (bitn < 8 && sel && rd && !addr_ph)
            sda_pull = !TX_BYTE[7 - bitn];
        // hold SCL low for the asked span
        if (stretch != 8'h00)
        begin
            scl_pull = 1'b1;
            // Release off the sampling edge so no process races the rise
            repeat (stretch) @(negedge clk_sys);
            scl_pull = 1'b0;
        end
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench: bus master against one slave model
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 4;
    localparam logic [6:0] SLV = 7'h2A;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic rsp_ready = 1'b0;
    logic [7:0] stretch = 8'h00;
    tw_pkg::tw_cmd_t cmd = '0;
    tw_pkg::tw_rsp_t rsp;
    tw_pkg::tw_rsp_t got;
    logic cmd_ready, rsp_valid, scl_oe, sda_oe, bus_busy, bus_owned, m_scl, m_sda;
    logic [7:0] rx_byte, rx_count;
    logic got_nack;
    logic scl_out, sda_out;
    logic sda_q = 1'b1;
    logic sda_moved = 1'b0;
    int n_errors = 0;
    int checks = 0;
    int hi_len = 0;
    int hi_min = 1000;
    int hi_max = 0;
    // Wired AND with pull-ups: a line is low if any party pulls
    wire scl = !(scl_oe || m_scl);
    wire sda = !(sda_oe || m_sda);

    always #2.5 clk_sys = !clk_sys;

    tw_master #(.Q_CYC(Q)) tw_master_i (
        .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
        .scl_i(scl), .scl_o(scl_out), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_out),
        .sda_oe(sda_oe),
        .bus_busy(bus_busy), .bus_owned(bus_owned)
    );
    tw_slave_model #(.ADDR(SLV), .TX_BYTE(8'hC3)) tw_slave_model_i (
        .clk_sys(clk_sys), .scl(scl), .sda(sda), .stretch(stretch), .scl_pull(m_scl),
        .sda_pull(m_sda), .rx_byte(rx_byte), .rx_count(rx_count), .got_nack(got_nack)
    );

    // Bit pulses carry no SDA edge; their high length is the master's own
    always @(posedge clk_sys)
    begin
        sda_q <= sda;
        if (scl)
        begin
            hi_len <= hi_len + 1;
            sda_moved <= sda_moved || (sda != sda_q);
        end
        else if (hi_len != 0)
        begin
            if (!sda_moved && hi_len < hi_min)
                hi_min <= hi_len;
            if (!sda_moved && hi_len > hi_max)
                hi_max <= hi_len;
            hi_len <= 0;
            sda_moved <= 1'b0;
        end
    end

    task automatic chk1(input string what, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // Flags are start, stop, rx, nack; held until the engine takes it
    task automatic send(input logic [3:0] f, input logic [7:0] d);
        int n = 0;
        @(negedge clk_sys);
        cmd <= {f, d};
        cmd_valid <= 1'b1;
        #1;
        while (cmd_ready !== 1'b1 && n < 5000)
        begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        chk1("cmd_ready", 1'b1, cmd_ready);
        @(negedge clk_sys);
        cmd_valid <= 1'b0;
    endtask

    task automatic recv();
        int n = 0;
        @(negedge clk_sys);
        while (rsp_valid !== 1'b1 && n < 5000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk1("rsp_valid", 1'b1, rsp_valid);
        got = rsp;
        rsp_ready <= 1'b1;
        @(negedge clk_sys);
        rsp_ready <= 1'b0;
    endtask

    // Expected flags e are nack, err, resv
    task automatic job(input logic [3:0] f, input logic [7:0] d, input logic [2:0] e);
        send(f, d);
        recv();
        chk8("rsp flags", {5'h00, e}, {5'h00, got.nack, got.err, got.resv});
    endtask

    task automatic idle_chk();
        int n = 0;
        // Ownership ends a few cycles after the wire shows the STOP
        while ((bus_busy !== 1'b0 || bus_owned !== 1'b0) && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk1("bus_busy", 1'b0, bus_busy);
        chk1("bus_owned", 1'b0, bus_owned);
    endtask

    task automatic t_write();
        job(4'h8, {SLV, 1'b0}, 3'h0);
        chk1("busy in frame", 1'b1, bus_busy);
        chk1("scl_o", 1'b0, scl_out);
        chk1("sda_o", 1'b0, sda_out);
        job(4'h4, 8'hA5, 3'h0);
        chk8("tx readback", 8'hA5, got.data);
        idle_chk();
        chk8("slave got", 8'hA5, rx_byte);
        $display("test write done");
    endtask

    task automatic t_read();
        job(4'h8, {SLV, 1'b1}, 3'h0);
        job(4'h7, 8'hFF, 3'h4);
        chk8("rx byte", 8'hC3, got.data);
        chk1("master nack", 1'b1, got_nack);
        idle_chk();
        $display("test read done");
    endtask

    task automatic t_special();
        job(4'hC, {7'h11, 1'b0}, 3'h4);
        idle_chk();
        job(4'h8, 8'h00, 3'h0);
        job(4'h4, 8'h3C, 3'h0);
        idle_chk();
        chk8("general call data", 8'h3C, rx_byte);
        job(4'hC, 8'h01, 3'h2);
        chk1("no bus action", 1'b0, bus_busy);
        job(4'hC, 8'hF0, 3'h5);
        idle_chk();
        job(4'h0, 8'h55, 3'h2);
        chk1("no frame", 1'b0, bus_busy);
        $display("test special done");
    endtask

    task automatic t_stretch();
        stretch <= 8'd20;
        job(4'h8, {SLV, 1'b0}, 3'h0);
        job(4'h8, {SLV, 1'b1}, 3'h0);
        chk1("busy on restart", 1'b1, bus_busy);
        chk1("owned on restart", 1'b1, bus_owned);
        job(4'h7, 8'hFF, 3'h4);
        chk8("rx stretched", 8'hC3, got.data);
        stretch <= 8'h00;
        idle_chk();
        chk1("high time steady", 1'b1, hi_min == hi_max);
        chk1("high time floor", 1'b1, hi_min >= 2 * Q);
        $display("test stretch done");
    endtask

    // Two results fill the buffer; the third job must stall before STOP
    task automatic t_buffer();
        int n = 0;
        logic [7:0] base;
        base = rx_count;
        send(4'h8, {SLV, 1'b0});
        send(4'h0, 8'h11);
        send(4'h4, 8'h22);
        while (rx_count !== base + 8'h02 && n < 2000)
        begin
            @(negedge clk_sys);
            n++;
        end
        repeat (60) @(negedge clk_sys);
        chk1("stop held back", 1'b1, bus_owned);
        chk1("rsp waiting", 1'b1, rsp_valid);
        recv();
        chk8("first out", {SLV, 1'b0}, got.data);
        recv();
        chk8("second out", 8'h11, got.data);
        recv();
        chk8("third out", 8'h22, got.data);
        idle_chk();
        $display("test buffer done");
    endtask

    task automatic final_report();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200us;
        n_errors++;
        $display("MISMATCH watchdog expected done seen hang");
        final_report();
    end

    initial
    begin
        repeat (16) @(negedge clk_sys);
        reset <= 1'b0;
        t_write();
        t_read();
        t_special();
        t_stretch();
        t_buffer();
        final_report();
    end
endmodule
